//--- common/duhp_regs.svh
// constants of the dual-channel host pin control: offsets, fields, timing
// assumes a 100 MHz ref_clk on both ends of the host bus
`ifndef DUHP_REGS_SVH
`define DUHP_REGS_SVH

// channel register offsets, fields and reset value on the host bus
`define DUHP_MCR_OFS      3'h4
`define DUHP_MSR_OFS      3'h6
`define DUHP_OVS_OFS      3'h7
`define DUHP_MCR_OP2_BIT  3
`define DUHP_MCR_PSC_BIT  7
`define DUHP_OVS_RST      8'h00

// timing
`define DUHP_CLK_MHZ      100
`define DUHP_RST_MIN_NS   40
`define DUHP_RST_CYC      ((`DUHP_RST_MIN_NS * `DUHP_CLK_MHZ + 999) / 1000)
`define DUHP_STB_CYC      12
`define DUHP_HOLD_CYC     6

// host control registers on AXI4-Lite
`define DUHP_CMD_OFS      4'h0
`define DUHP_STAT_OFS     4'h4
`define DUHP_CTRL_OFS     4'h8
`define DUHP_CMD_RD_BIT   13
`define DUHP_CTRL_STY_BIT 0
`define DUHP_CTRL_PSC_BIT 1
`define DUHP_CTRL_ISO_BIT 2
`define DUHP_CTRL_RST_BIT 3

`endif

//--- common/duhp_pkg.sv
// types shared by both ends of the host pin control
// assumes duhp_regs.svh for all numeric constants
package duhp_pkg;

  typedef enum logic [2:0] {
    HS_IDLE   = 3'b000,
    HS_SETUP  = 3'b001,
    HS_STROBE = 3'b011,
    HS_HOLD   = 3'b010,
    HS_RESET  = 3'b110
  } duhp_hstate_type;

  typedef enum logic [1:0] {
    OVS_16 = 2'h0,
    OVS_8  = 2'h1,
    OVS_4  = 2'h2
  } duhp_ovs_type;

endpackage

//--- common/duhp_bus_if.sv
// host bus pins between the host end and the dual-channel device end
// assumes both ends run on one ref_clk; data bus resolved here from enables
`timescale 1ns/1ps
`default_nettype none

interface duhp_bus_if;
  logic       bus_style;
  logic       rst_pin;
  logic       cha_select_n;
  logic       chb_select_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       channel_addr_bit;
  logic [2:0] addr;
  logic [7:0] hostData;
  logic       hostDataOe;
  logic [7:0] devData;
  logic       devDataOe;
  logic       bus_isolate_in;
  logic       prescale_strap;
  wire  [7:0] dataBus = hostDataOe ? hostData : (devDataOe ? devData : 8'hff);

  modport dev (
    input  bus_style, rst_pin, cha_select_n, chb_select_n, read_strobe_n,
    input  write_strobe_n, channel_addr_bit, addr, dataBus, bus_isolate_in,
    input  prescale_strap,
    output devData, devDataOe
  );

  modport host (
    output bus_style, rst_pin, cha_select_n, chb_select_n, read_strobe_n,
    output write_strobe_n, channel_addr_bit, addr, hostData, hostDataOe,
    output bus_isolate_in, prescale_strap,
    input  dataBus
  );
endinterface

`default_nettype wire

//--- logic/duhp_dev.sv
// device end: host bus decode, two channel register sets, reset and straps
// assumes host pins are asynchronous to ref_clk; serial core sits outside
`timescale 1ns/1ps
`default_nettype none
`include "duhp_regs.svh"

module duhp_dev
  import duhp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  duhp_bus_if.dev         bus,
  input  wire logic [1:0] txIn,
  input  wire logic [1:0] rxPin,
  input  wire logic [1:0] chIrqReq,
  input  wire logic       chb_set_ready_in,
  input  wire logic       chb_carrier_in,
  input  wire logic       chb_ring_in,
  output logic      [1:0] txPin,
  output logic      [1:0] rxCore,
  output logic      [1:0] bitTick,
  output logic            chanRst,
  output logic            cha_irq_out,
  output logic            cha_irq_oe,
  output logic            chb_irq_out,
  output logic            chb_irq_oe,
  output logic            cha_gp_out2,
  output logic            chb_gp_out2
);

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  localparam int NP = 25;

  wire logic [NP-1:0] pinRaw = {bus.bus_style, bus.rst_pin, bus.cha_select_n,
    bus.chb_select_n, bus.read_strobe_n, bus.write_strobe_n,
    bus.channel_addr_bit, bus.bus_isolate_in, bus.prescale_strap, bus.addr,
    bus.dataBus, rxPin, chb_set_ready_in, chb_carrier_in, chb_ring_in};

  logic [NP-1:0] s1_r;
  logic [NP-1:0] s2_r;
  logic [NP-1:0] s3_r;
  logic [NP-1:0] pin_r;

  // a bit moves only once the second and third stages agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      pin_r <= '1;
    end else begin
      s1_r  <= pinRaw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
    end
  end

  wire logic       style  = pin_r[24];
  wire logic       rstPn  = pin_r[23];
  wire logic       csAN   = pin_r[22];
  wire logic       csBN   = pin_r[21];
  wire logic       rdN    = pin_r[20];
  wire logic       wrN    = pin_r[19];
  wire logic       chBit  = pin_r[18];
  wire logic       iso    = pin_r[17];
  wire logic       strap  = pin_r[16];
  wire logic [2:0] adr    = pin_r[15:13];
  wire logic [7:0] dIn    = pin_r[12:5];
  wire logic [1:0] rxS    = pin_r[4:3];
  wire logic       dsrN   = pin_r[2];
  wire logic       cdN    = pin_r[1];
  wire logic       riN    = pin_r[0];

  // ****************************************************************
  // reset and bus decode
  // ****************************************************************
  wire logic       rstAct = style ? rstPn : ~rstPn;
  // strobe style: each low select picks its channel, both allowed
  wire logic [1:0] selS   = {~csBN, ~csAN};
  // rw style: one select, address bit picks the channel
  wire logic [1:0] selM   = csAN ? 2'b00 : (chBit ? 2'b10 : 2'b01);
  wire logic [1:0] sel    = style ? selS : selM;
  wire logic       busOk  = (|sel) & ~iso & ~rstAct;
  wire logic       rdAct  = busOk & (style ? ~rdN : rdN);
  wire logic       wrAct  = busOk & (style ? ~wrN : ~rdN);

  logic       wrHold_r;
  logic [1:0] wrSel_r;
  logic [2:0] wrAdr_r;
  logic [7:0] wrDat_r;

  // a write lands when its strobe ends; isolation abandons it
  wire logic       commit = wrHold_r & ~wrAct & ~iso & ~rstAct;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrHold_r <= 1'b0;
      wrSel_r  <= 2'b00;
      wrAdr_r  <= 3'h0;
      wrDat_r  <= 8'h00;
    end else begin
      wrHold_r <= wrAct;
      if (wrAct) begin
        wrSel_r <= sel;
        wrAdr_r <= adr;
        wrDat_r <= dIn;
      end
    end
  end

  // ****************************************************************
  // channel registers and prescaler
  // ****************************************************************
  logic [7:0] regs_r [2][8];
  logic       prescDiv4_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int a = 0; a < 8; a++) begin
          regs_r[c][a] <= 8'h00;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int a = 0; a < 8; a++) begin
          if (rstAct) begin
            regs_r[c][a] <= 8'h00;
          end else if (commit && wrSel_r[c] && wrAdr_r == 3'(a)) begin
            regs_r[c][a] <= wrDat_r;
          end
        end
      end
    end
  end

  // strap is caught only while reset is held, later swings do nothing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescDiv4_r <= 1'b0;
    end else if (rstAct) begin
      prescDiv4_r <= ~strap;
    end else if (commit && wrAdr_r == `DUHP_MCR_OFS) begin
      prescDiv4_r <= wrDat_r[`DUHP_MCR_PSC_BIT];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // channel a wins if the host breaks the no-dual-read rule
  wire logic       rdCh = ~sel[0];

  function automatic logic [7:0] regRead(input logic [7:0] r, input logic ch,
                                         input logic [2:0] a, input logic psc,
                                         input logic [2:0] mdm);
    logic [7:0] v;
    v = r;
    if (a == `DUHP_MCR_OFS) begin
      v[`DUHP_MCR_PSC_BIT] = psc;
    end
    // modem inputs of channel b only report status
    if (ch && a == `DUHP_MSR_OFS) begin
      v[7:5] = mdm;
    end
    return v;
  endfunction

  // all read inputs are arguments, so the wire re-evaluates on register writes
  wire logic [7:0] rdVal = regRead(regs_r[rdCh][adr], rdCh, adr, prescDiv4_r,
                                   {~cdN, ~riN, ~dsrN});
  logic [7:0] devData_r;
  logic       devDataOe_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      devData_r   <= 8'h00;
      devDataOe_r <= 1'b0;
    end else begin
      devData_r   <= rdAct ? rdVal : 8'h00;
      devDataOe_r <= rdAct;
    end
  end

  assign bus.devData   = devData_r;
  assign bus.devDataOe = devDataOe_r;

  // ****************************************************************
  // baud sample ticks
  // ****************************************************************
  function automatic logic [3:0] ovsTop(input logic [1:0] s);
    case (duhp_ovs_type'(s))
      OVS_8:   ovsTop = 4'h7;
      OVS_4:   ovsTop = 4'h3;
      default: ovsTop = 4'hf;
    endcase
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0] psc_r;
    logic [3:0] ovs_r;
    logic       tk_r;
    wire  logic pscHit = prescDiv4_r ? (psc_r == 2'h3) : 1'b1;
    wire  logic [3:0] top = ovsTop(regs_r[c][`DUHP_OVS_OFS][1:0]);

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        psc_r <= 2'h0;
        ovs_r <= 4'h0;
        tk_r  <= 1'b0;
      end else if (rstAct) begin
        psc_r <= 2'h0;
        ovs_r <= 4'h0;
        tk_r  <= 1'b0;
      end else begin
        psc_r <= pscHit ? 2'h0 : psc_r + 2'h1;
        tk_r  <= pscHit && ovs_r == top;
        if (pscHit) begin
          ovs_r <= (ovs_r == top) ? 4'h0 : ovs_r + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // serial side and output-port-2 / irq pins
  // ****************************************************************
  logic [1:0] tx_r;
  logic [1:0] rx_r;
  logic [1:0] irq_r;
  logic [1:0] irqOe_r;
  logic [1:0] op2_r;
  logic       rst_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r    <= 2'b11;
      rx_r    <= 2'b11;
      irq_r   <= 2'b00;
      irqOe_r <= 2'b00;
      op2_r   <= 2'b11;
      rst_r   <= 1'b1;
    end else begin
      rst_r <= rstAct;
      for (int c = 0; c < 2; c++) begin
        tx_r[c]    <= rstAct | txIn[c];
        rx_r[c]    <= rstAct | rxS[c];
        irq_r[c]   <= ~rstAct & chIrqReq[c];
        // host keeps op2 for the irq enable when it uses the irq line
        irqOe_r[c] <= ~rstAct & regs_r[c][`DUHP_MCR_OFS][`DUHP_MCR_OP2_BIT];
        op2_r[c]   <= rstAct | ~regs_r[c][`DUHP_MCR_OFS][`DUHP_MCR_OP2_BIT];
      end
    end
  end

  assign txPin       = tx_r;
  assign rxCore      = rx_r;
  assign bitTick     = {g_ch[1].tk_r, g_ch[0].tk_r};
  assign chanRst     = rst_r;
  assign cha_irq_out = irq_r[0];
  assign chb_irq_out = irq_r[1];
  assign cha_irq_oe  = irqOe_r[0];
  assign chb_irq_oe  = irqOe_r[1];
  assign cha_gp_out2 = op2_r[0];
  assign chb_gp_out2 = op2_r[1];

endmodule

`default_nettype wire

//--- logic/duhp_host.sv
// host end: AXI4-Lite control registers driving the parallel host bus pins
// assumes device end on the same interface; its read data is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "duhp_regs.svh"

module duhp_host
  import duhp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  duhp_bus_if.host         bus
);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        awGot_r, wGot_r, awRdy_r, wRdy_r, bVal_r, arRdy_r, rVal_r;
  logic [3:0]  awA_r;
  logic [31:0] wD_r;
  logic [31:0] rD_r;

  wire logic awTake  = awvalid & awRdy_r;
  wire logic wTake   = wvalid & wRdy_r;
  wire logic gotA    = awGot_r | awTake;
  wire logic gotW    = wGot_r | wTake;
  wire logic doWr    = gotA & gotW;
  wire logic bNxt    = doWr | (bVal_r & ~bready);
  wire logic arTake  = arvalid & arRdy_r;
  wire logic rNxt    = arTake | (rVal_r & ~rready);
  wire logic [3:0]  wA = awTake ? awaddr : awA_r;
  wire logic [31:0] wD = wTake ? wdata : wD_r;

  logic            busy_r;
  logic [7:0]      rdByte_r;
  logic [2:0]      ctrl_r;
  wire logic [31:0] statV = {16'h0000, rdByte_r, 7'h00, busy_r};
  wire logic [31:0] rdMux = (araddr == `DUHP_STAT_OFS) ? statV :
                            (araddr == `DUHP_CTRL_OFS) ? {29'h0, ctrl_r} : 32'h0;
  wire logic wstrbOk = wTake ? wstrb[0] : 1'b1;
  wire logic cmdWr  = doWr && wA == `DUHP_CMD_OFS && !busy_r && wstrbOk;
  wire logic ctrlWr = doWr && wA == `DUHP_CTRL_OFS && wstrbOk;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awGot_r <= 1'b0;
      wGot_r  <= 1'b0;
      awRdy_r <= 1'b1;
      wRdy_r  <= 1'b1;
      bVal_r  <= 1'b0;
      arRdy_r <= 1'b1;
      rVal_r  <= 1'b0;
      awA_r   <= 4'h0;
      wD_r    <= 32'h0;
      rD_r    <= 32'h0;
    end else begin
      awGot_r <= gotA & ~doWr;
      wGot_r  <= gotW & ~doWr;
      awRdy_r <= ~(gotA & ~doWr) & ~bNxt;
      wRdy_r  <= ~(gotW & ~doWr) & ~bNxt;
      bVal_r  <= bNxt;
      arRdy_r <= ~rNxt;
      rVal_r  <= rNxt;
      awA_r   <= wA;
      wD_r    <= wD;
      if (arTake) begin
        rD_r <= rdMux;
      end
    end
  end

  assign awready = awRdy_r;
  assign wready  = wRdy_r;
  assign bvalid  = bVal_r;
  assign bresp   = 2'b00;
  assign arready = arRdy_r;
  assign rvalid  = rVal_r;
  assign rdata   = rD_r;
  assign rresp   = 2'b00;

  // ****************************************************************
  // pin sequencer
  // ****************************************************************
  duhp_hstate_type st_r, stNxt;
  logic [3:0]  cnt_r;
  logic [13:0] cmd_r;
  logic [7:0]  d1_r, d2_r, d3_r, dF_r;

  wire logic cmdRd = cmd_r[`DUHP_CMD_RD_BIT];
  wire logic [3:0] cntTop = (st_r == HS_STROBE) ? 4'(`DUHP_STB_CYC - 1) :
                            (st_r == HS_HOLD)   ? 4'(`DUHP_HOLD_CYC - 1) :
                                                  4'(`DUHP_RST_CYC - 1);
  wire logic last = cnt_r == cntTop;
  wire logic rstGo = ctrlWr && wD[`DUHP_CTRL_RST_BIT] && !busy_r;

  always_comb begin
    stNxt = st_r;
    case (st_r)
      HS_IDLE:   stNxt = rstGo ? HS_RESET : (cmdWr ? HS_SETUP : HS_IDLE);
      HS_SETUP:  stNxt = HS_STROBE;
      HS_STROBE: stNxt = last ? HS_HOLD : HS_STROBE;
      HS_HOLD:   stNxt = last ? HS_IDLE : HS_HOLD;
      HS_RESET:  stNxt = last ? HS_IDLE : HS_RESET;
      default:   stNxt = HS_IDLE;
    endcase
  end

  wire logic stbN  = stNxt == HS_STROBE;
  wire logic sty   = ctrl_r[`DUHP_CTRL_STY_BIT];
  wire logic [1:0] msk = cmd_r[12:11];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r     <= HS_IDLE;
      cnt_r    <= 4'h0;
      cmd_r    <= 14'h0;
      busy_r   <= 1'b0;
      ctrl_r   <= 3'b011;
      rdByte_r <= 8'h00;
      d1_r     <= 8'h00;
      d2_r     <= 8'h00;
      d3_r     <= 8'h00;
      dF_r     <= 8'h00;
    end else begin
      st_r   <= stNxt;
      cnt_r  <= (stNxt != st_r) ? 4'h0 : cnt_r + 4'h1;
      busy_r <= stNxt != HS_IDLE;
      d1_r   <= bus.dataBus;
      d2_r   <= d1_r;
      d3_r   <= d2_r;
      dF_r   <= (d2_r & d3_r) | (dF_r & (d2_r ^ d3_r));
      if (cmdWr) begin
        cmd_r <= wD[13:0];
      end
      if (ctrlWr && !busy_r) begin
        ctrl_r <= wD[2:0];
      end
      if (st_r == HS_STROBE && last && cmdRd) begin
        rdByte_r <= dF_r;
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic pStyle_r, pRst_r, pCsA_r, pCsB_r, pRd_r, pWr_r, pA3_r, pOe_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pStyle_r <= 1'b1;
      pRst_r   <= 1'b0;
      pCsA_r   <= 1'b1;
      pCsB_r   <= 1'b1;
      pRd_r    <= 1'b1;
      pWr_r    <= 1'b1;
      pA3_r    <= 1'b0;
      pOe_r    <= 1'b0;
    end else begin
      pStyle_r <= sty;
      pRst_r   <= (stNxt == HS_RESET) ~^ sty;
      pCsA_r   <= ~(stbN & (sty ? msk[0] : 1'b1));
      pCsB_r   <= ~(stbN & sty & msk[1]);
      pRd_r    <= sty ? ~(stbN & cmdRd) : (stNxt == HS_IDLE) | cmdRd;
      pWr_r    <= ~(stbN & sty & ~cmdRd);
      pA3_r    <= ~sty & msk[1];
      // the new command's direction already applies in its setup cycle
      pOe_r    <= ~(cmdWr ? wD[`DUHP_CMD_RD_BIT] : cmdRd) &&
                  (stNxt == HS_SETUP || stNxt == HS_STROBE ||
                             stNxt == HS_HOLD);
    end
  end

  assign bus.bus_style        = pStyle_r;
  assign bus.rst_pin          = pRst_r;
  assign bus.cha_select_n     = pCsA_r;
  assign bus.chb_select_n     = pCsB_r;
  assign bus.read_strobe_n    = pRd_r;
  assign bus.write_strobe_n   = pWr_r;
  assign bus.channel_addr_bit = pA3_r;
  assign bus.addr             = cmd_r[10:8];
  assign bus.hostData         = cmd_r[7:0];
  assign bus.hostDataOe       = pOe_r;
  assign bus.bus_isolate_in   = ctrl_r[`DUHP_CTRL_ISO_BIT];
  assign bus.prescale_strap   = ctrl_r[`DUHP_CTRL_PSC_BIT];

endmodule

`default_nettype wire

//--- dv/duhp_monitor.sv
// checker on the host bus pins joining the host end and the device end
// assumes one ref_clk; instantiated beside the interface, no bind
`timescale 1ns/1ps
`default_nettype none

module duhp_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bus_style,
  input wire logic rst_pin,
  input wire logic cha_select_n,
  input wire logic chb_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic bus_isolate_in
);
  // reset polarity and read decode both follow the style pin
  wire logic rstAct = bus_style ? rst_pin : !rst_pin;
  wire logic anySel = !(cha_select_n && chb_select_n);
  wire logic rdAct  = bus_style ? (!read_strobe_n && anySel) : (!cha_select_n && read_strobe_n);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ************************************************
  // sequences and properties
  // ************************************************
  sequence s_held;
    (!write_strobe_n && hostDataOe)[*8];
  endsequence
  property p_isoQuiet; bus_isolate_in[*4] |-> !devDataOe; endproperty
  property p_rstQuiet; rstAct[*4] |-> !devDataOe; endproperty
  property p_oeIdle; (!rdAct)[*8] |-> !devDataOe; endproperty
  property p_noClash; !(hostDataOe && devDataOe); endproperty
  property p_wrSel; !write_strobe_n |-> bus_style && anySel; endproperty
  property p_rwNoWr; !bus_style |-> write_strobe_n; endproperty
  property p_noDualRd; bus_style && !read_strobe_n |-> anySel && !(!cha_select_n && !chb_select_n);
  endproperty
  property p_strobeWidth; $fell(write_strobe_n) |-> s_held; endproperty
  property p_rstPulse; bus_style && $rose(rst_pin) |-> rst_pin[*4]; endproperty

  a_isoQuiet: assert property (p_isoQuiet)
    else $error("data driven while isolated");
  a_rstQuiet: assert property (p_rstQuiet)
    else $error("data driven in reset");
  a_oeIdle: assert property (p_oeIdle)
    else $error("data driven with no read");
  a_noClash: assert property (p_noClash)
    else $error("both ends drive data");
  a_wrSel: assert property (p_wrSel)
    else $error("write strobe without select");
  a_rwNoWr: assert property (p_rwNoWr)
    else $error("write strobe in rw style");
  a_noDualRd: assert property (p_noDualRd)
    else $error("read with bad selects");
  a_strobeWidth: assert property (p_strobeWidth)
    else $error("write strobe too short");
  a_rstPulse: assert property (p_rstPulse)
    else $error("reset pulse too short");
endmodule

`default_nettype wire

//--- dv/duart_host_pin_control_test.sv
// self-checking bench: axi-lite host end driving the device end
// assumes design files, interface and duhp_regs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "duhp_regs.svh"
`define CHK(nm, got, exp) begin samplesChecked++; if ((got) !== (exp)) begin failCount++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end

module duart_host_pin_control_test;
  logic ref_clk = 1'b0, arst_n = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, chanRst;
  logic [1:0] bresp, rresp, txPin, rxCore, bitTick;
  logic [1:0] txIn = 2'h3, rxPin = 2'h3, chIrqReq = 2'h0;
  logic setRdy = 1'b1, carrier = 1'b1, ring = 1'b1;
  logic cha_irq_out, cha_irq_oe, chb_irq_out, chb_irq_oe, cha_gp_out2, chb_gp_out2;
  integer seed = 32'had59;
  int failCount = 0, samplesChecked = 0;
  logic [32:0] expQ[$];
  logic [32:0] e;
  logic [1:0] rq1, rq2, rq3, rqF, rqP, txPrev, irqPrev;

  duhp_bus_if busIf();
  duhp_dev duhp_dev_i (.ref_clk, .arst_n, .bus(busIf), .txIn, .rxPin, .chIrqReq,
    .chb_set_ready_in(setRdy), .chb_carrier_in(carrier), .chb_ring_in(ring), .txPin, .rxCore,
    .bitTick, .chanRst, .cha_irq_out, .cha_irq_oe, .chb_irq_out, .chb_irq_oe, .cha_gp_out2,
    .chb_gp_out2);
  duhp_host duhp_host_i (.ref_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .bus(busIf));
  duhp_monitor duhp_monitor_i (.ref_clk, .arst_n, .bus_style(busIf.bus_style),
    .rst_pin(busIf.rst_pin), .cha_select_n(busIf.cha_select_n),
    .chb_select_n(busIf.chb_select_n), .read_strobe_n(busIf.read_strobe_n),
    .write_strobe_n(busIf.write_strobe_n), .hostDataOe(busIf.hostDataOe),
    .devDataOe(busIf.devDataOe), .bus_isolate_in(busIf.bus_isolate_in));

  always #5 ref_clk = ~ref_clk;

  // serial-side inputs wander; txPin and irq outputs follow them one clock later, rxCore follows rxPin through the pin synchroniser
  always @(posedge ref_clk) begin
    if (arst_n) begin
      `CHK("txPin", txPin, txPrev | {2{chanRst}})
      `CHK("rxCore", rxCore, rqP | {2{chanRst}})
      `CHK("irqOut", {chb_irq_out, cha_irq_out}, irqPrev & ~{2{chanRst}})
    end
    // pin model: three stages, a level counts once stages two and three agree
    rq1 <= arst_n ? rxPin : 2'h3;
    rq2 <= arst_n ? rq1 : 2'h3;
    rq3 <= arst_n ? rq2 : 2'h3;
    rqF <= arst_n ? ((rq2 & rq3) | (rqF & (rq2 ^ rq3))) : 2'h3;
    rqP <= rqF;
    txPrev <= txIn;
    irqPrev <= chIrqReq;
    txIn <= 2'($random(seed));
    rxPin <= 2'($random(seed));
    chIrqReq <= 2'($random(seed));
    {setRdy, carrier, ring} <= 3'($random(seed));
  end

  // ************************************************
  // result watcher: oldest note against each read
  // ************************************************
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      e = expQ.pop_front();
      if (e[32]) `CHK("rdata", rdata, e[31:0])
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic c, input logic [31:0] x);
    @(posedge ref_clk);
    expQ.push_back({c, x});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rready <= 1'b0;
  endtask

  // one host bus access, then poll until the host end is idle
  task automatic cmd(input logic r, input logic [1:0] m, input logic [2:0] a, input logic [7:0] d);
    wr(`DUHP_CMD_OFS, {18'h0, r, m, a, d});
    do rd(`DUHP_STAT_OFS, 1'b0, 32'h0); while (rv[0] !== 1'b0);
  endtask

  task automatic rdByte(input logic [1:0] m, input logic [2:0] a, input logic [7:0] x);
    cmd(1'b1, m, a, 8'h00);
    rd(`DUHP_STAT_OFS, 1'b1, {16'h0, x, 8'h00});
  endtask

  task automatic ctrl(input logic [31:0] d);
    wr(`DUHP_CTRL_OFS, d);
    repeat (12) @(posedge ref_clk);
  endtask

  // cycles between two channel a bit ticks
  task automatic tickGap(input int x);
    int n;
    n = 0;
    @(posedge ref_clk iff bitTick[0]);
    do begin
      @(posedge ref_clk);
      n++;
    end while (bitTick[0] !== 1'b1);
    `CHK("tickGap", n, x)
  endtask

  task conclude;
    $display("checked %0d mismatched %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    conclude;
  end

  initial begin
    logic [7:0] ov;
    repeat (2) @(posedge ref_clk);
    `CHK("txPin", txPin, 2'h3)
    `CHK("gpA", cha_gp_out2, 1'b1)
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK("chanRst", chanRst, 1'b0)
    $display("test reset done");
    cmd(1'b0, 2'b01, `DUHP_MCR_OFS, 8'h08);
    `CHK("gpA", cha_gp_out2, 1'b0)
    `CHK("irqOeA", cha_irq_oe, 1'b1)
    `CHK("gpB", chb_gp_out2, 1'b1)
    rdByte(2'b01, `DUHP_MCR_OFS, 8'h08);
    $display("test op2 done");
    for (int i = 0; i < 3; i++) begin
      ov = 8'($unsigned($random(seed)) % 3);
      cmd(1'b0, 2'b10, `DUHP_OVS_OFS, ov);
      rdByte(2'b10, `DUHP_OVS_OFS, ov);
    end
    cmd(1'b0, 2'b11, `DUHP_OVS_OFS, 8'h01);
    rdByte(2'b01, `DUHP_OVS_OFS, 8'h01);
    tickGap(8);
    $display("test oversample done");
    ctrl(32'h9);
    `CHK("gpA", cha_gp_out2, 1'b1)
    rdByte(2'b01, `DUHP_MCR_OFS, 8'h80);
    tickGap(64);
    ctrl(32'h3);
    rdByte(2'b01, `DUHP_MCR_OFS, 8'h80);
    ctrl(32'hb);
    rdByte(2'b01, `DUHP_MCR_OFS, 8'h00);
    cmd(1'b0, 2'b01, `DUHP_MCR_OFS, 8'h80);
    rdByte(2'b01, `DUHP_MCR_OFS, 8'h80);
    $display("test prescaler done");
    ctrl(32'h2);
    cmd(1'b0, 2'b01, `DUHP_MCR_OFS, 8'h00);
    cmd(1'b0, 2'b11, `DUHP_MCR_OFS, 8'h08);
    `CHK("gpA", cha_gp_out2, 1'b1)
    `CHK("gpB", chb_gp_out2, 1'b0)
    `CHK("irqOeB", chb_irq_oe, 1'b1)
    rdByte(2'b11, `DUHP_MCR_OFS, 8'h08);
    $display("test rw style done");
    ctrl(32'h6);
    cmd(1'b0, 2'b11, `DUHP_MCR_OFS, 8'h00);
    `CHK("gpB", chb_gp_out2, 1'b0)
    rdByte(2'b11, `DUHP_MCR_OFS, 8'hff);
    $display("test isolate done");
    rd(4'hc, 1'b1, 32'h0);
    $display("test unmapped done");
    conclude;
  end
endmodule

`default_nettype wire
